/* core/oss_core.sv */
/*
 Oscillator source select and system clock generation.
 Assumes the four oscillator outputs arrive as free levels
 from analog cells outside the i_clk domain, sampled at 20 MHz,
 and that halt, wake and watchdog enable come from i_clk logic.
*/
// Functional notes
// R1 - Four oscillators: two fast, two slow
// R2 - Fast RC has 4/8/12 MHz, no pins
// R3 - Slow sources: 32 kHz RC, 32.768 kHz crystal
// R4 - Three-bit field picks fast or slow, dynamically
// R5 - Separate select bits for fast and slow
// R6 - Same field sets system clock divider
// R7 - Always one fast and one slow source
// R8 - Oscillators also feed watchdog and time base
// R9 - Slow crystal starts on enable, then delay
// R10 - Sleep/idle stop system clock, timers may run; o_sysclk runs on in halt if the current path's idle-enable bit is set
// R11 - Pin-share bits free crystal pins for I/O
// R12 - Fast clock divided by 1 to 64
// R13 - Idle-enable bits choose sleep or idle variant
// R14 - Source and divider changes are glitch-free
// R15 - Ready flag per oscillator gates switching
`timescale 1ns/100ps
module oss_core (
	input  wire logic                       i_clk,
	input  wire logic                       i_nrst,
	input  wire logic                       i_fast_crystal_osc,
	input  wire logic                       i_fast_internal_rc,
	input  wire logic                       i_slow_crystal_osc,
	input  wire logic                       i_slow_internal_rc,
	input  wire logic [oss_pkg::ADDR_W-1:0] i_addr,
	input  wire logic [oss_pkg::DATA_W-1:0] i_wdata,
	input  wire logic                       i_wr,
	input  wire logic                       i_rd,
	input  wire logic                       i_halt,
	input  wire logic                       i_wake,
	input  wire logic                       i_wdt_en,
	output logic      [oss_pkg::DATA_W-1:0] o_rdata,
	output logic                            o_sysclk,
	output logic                            o_fast_clk,
	output logic                            o_sub_clk,
	output logic                            o_slow_internal_rc_clk,
	output logic                            o_fxt_en,
	output logic                            o_frc_en,
	output logic                            o_sxt_en,
	output logic                            o_src_en,
	output logic      [1:0]                 o_frc_freq,
	output logic                            o_xt_pins_osc,
	output logic                            o_cpu_run
);
	import oss_pkg::*;

	// ==========================================================
	// Registers and their next values
	logic [7:0]         sysctl, next_sysctl;
	logic [1:0]         frq, next_frq;
	logic               frc_en, next_frc_en;
	logic               fxt_en, next_fxt_en;
	logic               sxt_en, next_sxt_en;
	logic               xtps, next_xtps;
	logic [DATA_W-1:0]  next_rdata;
	logic [N_OSC-1:0]   osc_in, lvl, rise, rdy, en;
	logic               halted, next_halted;
	logic [2:0]         cur_cks, next_cks;
	logic               cur_fhs, next_fhs;
	logic               cur_fss, next_fss;
	logic               hold, next_hold;
	logic               sys_run, next_run;
	logic [DIV_W-1:0]   div_cnt, next_div;
	logic               next_sys;
	logic               fast_lvl, sub_lvl, fast_rise, sub_rise;
	logic               fast_need, slow_need, path, sw, sys_req;
	logic               req_rdy, sxt_used;
	logic [2:0]         req_cks;

	assign osc_in = {i_slow_internal_rc, i_slow_crystal_osc,
		i_fast_internal_rc, i_fast_crystal_osc};         // R1 R3
	assign req_cks = sysctl[B_CKS_HI:B_CKS_LO];

	// ==========================================================
	// Per-oscillator sampler and start-up counter
	// Three-stage sampler; a level counts once stages 2 and 3 agree
	for (genvar g = 0; g < N_OSC; g++) begin : g_osc
		logic [2:0]         smp;
		logic               nl, nr, nrdy;
		logic [START_W-1:0] cnt, ncnt;
		always_comb begin
			nl = (smp[1] == smp[2]) ? smp[2] : lvl[g];
			nr = nl & ~lvl[g];
			ncnt = cnt;
			if (!en[g])
				ncnt = '0;                                  // R9
			else if (nr && !rdy[g])
				ncnt = cnt + 1'b1;
			nrdy = en[g] && (ncnt == START_EDGES[g]);       // R15
		end
		always_ff @(posedge i_clk or negedge i_nrst) begin
			if (!i_nrst) begin
				smp     <= '0;
				lvl[g]  <= 1'b0;
				rise[g] <= 1'b0;
				cnt     <= '0;
				rdy[g]  <= 1'b0;
			end else begin
				smp     <= {smp[1:0], osc_in[g]};
				lvl[g]  <= nl;
				rise[g] <= nr;
				cnt     <= ncnt;
				rdy[g]  <= nrdy;
			end
		end
	end

	// ==========================================================
	// Register port: writes, reads and halt state
	always_comb begin
		next_sysctl = sysctl;
		next_frq    = frq;
		next_frc_en = frc_en;
		next_fxt_en = fxt_en;
		next_sxt_en = sxt_en;
		next_xtps   = xtps;
		next_rdata  = '0;
		if (i_wr) begin
			case (i_addr)
				A_SYSCTL: next_sysctl = i_wdata & SYSCTL_WM;   // R4 R5
				A_FRCCTL: begin
					next_frq    = i_wdata[B_FRQ_HI:B_FRQ_LO];   // R2
					next_frc_en = i_wdata[B_EN];
				end
				A_FXTCTL: next_fxt_en = i_wdata[B_EN];
				A_SXTCTL: next_sxt_en = i_wdata[B_EN];         // R9
				A_PINCTL: next_xtps   = i_wdata[B_XTPS];       // R11
				default: ;
			endcase
		end
		if (i_rd) begin
			case (i_addr)
				A_SYSCTL: next_rdata = sysctl;
				A_FRCCTL: next_rdata = {4'h0, frq, rdy[OSC_FRC], frc_en};
				A_FXTCTL: next_rdata = {6'h00, rdy[OSC_FXT], fxt_en};
				A_SXTCTL: next_rdata = {6'h00, rdy[OSC_SXT], sxt_en};
				A_PINCTL: next_rdata = {7'h00, xtps};
				default:  next_rdata = '0;
			endcase
		end
		// Wake wins over halt so an early wake is not lost
		next_halted = halted;
		if (i_halt)
			next_halted = 1'b1;
		if (i_wake)
			next_halted = 1'b0;
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			sysctl  <= SYSCTL_RST;
			frq     <= FRQ_RST;
			frc_en  <= FRC_EN_RST;
			fxt_en  <= 1'b0;
			sxt_en  <= 1'b0;
			xtps    <= 1'b0;
			o_rdata <= '0;
			halted  <= 1'b0;
		end else begin
			sysctl  <= next_sysctl;
			frq     <= next_frq;
			frc_en  <= next_frc_en;
			fxt_en  <= next_fxt_en;
			sxt_en  <= next_sxt_en;
			xtps    <= next_xtps;
			o_rdata <= next_rdata;
			halted  <= next_halted;
		end
	end

	// ==========================================================
	// Oscillator enables and clock outputs
	// Halt keeps each path only if its idle-enable bit is set; i_wdt_en alone keeps the slow RC and o_slow_internal_rc_clk running
	always_comb begin
		fast_need = !halted || sysctl[B_FHID];              // R13
		slow_need = !halted || sysctl[B_FSID];              // R13
		// Requested fast source is started so a switch can finish
		en[OSC_FXT] = fast_need && (fxt_en || sysctl[B_FHS]);
		en[OSC_FRC] = fast_need && (frc_en || !sysctl[B_FHS]);
		// Slow crystal never starts without its enable bit
		en[OSC_SXT] = slow_need && sxt_en;                  // R9
		en[OSC_SRC] = slow_need || i_wdt_en;                // R8
		sxt_used    = sxt_en || cur_fss;                    // R11
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_fast_clk    <= 1'b0;
			o_sub_clk     <= 1'b0;
			o_slow_internal_rc_clk    <= 1'b0;
			o_fxt_en      <= 1'b0;
			o_frc_en      <= 1'b0;
			o_sxt_en      <= 1'b0;
			o_src_en      <= 1'b0;
			o_frc_freq    <= FRQ_RST;
			o_xt_pins_osc <= 1'b0;
			o_cpu_run     <= 1'b0;
		end else begin
			o_fast_clk    <= fast_need && fast_lvl;         // R8 R10
			o_sub_clk     <= slow_need && sub_lvl;          // R8 R10
			o_slow_internal_rc_clk    <= en[OSC_SRC] && lvl[OSC_SRC];   // R8
			o_fxt_en      <= en[OSC_FXT];
			o_frc_en      <= en[OSC_FRC];
			o_sxt_en      <= en[OSC_SXT];
			o_src_en      <= en[OSC_SRC];
			o_frc_freq    <= frq;                           // R2
			o_xt_pins_osc <= xtps || sxt_used;              // R11
			o_cpu_run     <= !halted;
		end
	end

	// ==========================================================
	// System clock source switch and divider
	// A switch lands only while the output is and stays low, then
	// holds low until the new source rises: no short pulse
	always_comb begin
		fast_lvl  = cur_fhs ? lvl[OSC_FXT] : lvl[OSC_FRC];  // R5 R7
		fast_rise = cur_fhs ? rise[OSC_FXT] : rise[OSC_FRC];
		sub_lvl   = cur_fss ? lvl[OSC_SXT] : lvl[OSC_SRC];  // R5 R7
		sub_rise  = cur_fss ? rise[OSC_SXT] : rise[OSC_SRC];
		next_div  = fast_rise ? div_cnt + 1'b1 : div_cnt;   // R12
		if (cur_cks == CKS_SUB)
			path = sub_lvl;                                 // R4
		else if (cur_cks == CKS_DIV1)
			path = fast_lvl;
		else
			path = div_cnt[cur_cks - 3'h1];                 // R6 R12
		req_rdy = rdy[sysctl[B_FHS] ? OSC_FXT : OSC_FRC] &&
			rdy[sysctl[B_FSS] ? OSC_SXT : OSC_SRC];         // R15
		sys_req = !halted || ((cur_cks == CKS_SUB) ?
			sysctl[B_FSID] : sysctl[B_FHID]);               // R10 R13
		sw = req_rdy && !o_sysclk && !path && ({req_cks,
			sysctl[B_FHS], sysctl[B_FSS]} !=
			{cur_cks, cur_fhs, cur_fss});                   // R14
		next_cks  = cur_cks;
		next_fhs  = cur_fhs;
		next_fss  = cur_fss;
		next_hold = hold;
		next_run  = sys_run;
		if (sw) begin
			next_cks  = req_cks;                            // R4
			next_fhs  = sysctl[B_FHS];
			next_fss  = sysctl[B_FSS];
			next_hold = 1'b1;
			next_div  = '0;
		end else if (hold && (cur_cks == CKS_SUB ?
				sub_rise : fast_rise)) begin
			next_hold = 1'b0;
		end
		// Gate off only at a low phase; restart through hold
		if (!sys_req && !o_sysclk && !path)
			next_run = 1'b0;                                // R10
		else if (sys_req && !sys_run) begin
			next_run  = 1'b1;
			next_hold = 1'b1;
		end
		next_sys = sys_run && !hold && path;                // R14
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cur_cks  <= CKS_DIV1;
			cur_fhs  <= 1'b0;
			cur_fss  <= 1'b0;
			hold     <= 1'b1;
			sys_run  <= 1'b1;
			div_cnt  <= '0;
			o_sysclk <= 1'b0;
		end else begin
			cur_cks  <= next_cks;
			cur_fhs  <= next_fhs;
			cur_fss  <= next_fss;
			hold     <= next_hold;
			sys_run  <= next_run;
			div_cnt  <= next_div;
			o_sysclk <= next_sys;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	sequence s_switch;
		$changed(cur_cks) || $changed(cur_fhs) || $changed(cur_fss);
	endsequence
	sequence s_low2;
		!o_sysclk ##1 !o_sysclk;
	endsequence

	property p_glitch;                                      // R14
		s_switch |-> s_low2;
	endproperty
	a_glitch: assert property (p_glitch)                    // R14
		else $error("switch while system clock high");
	property p_ready;                                       // R15
		s_switch |-> $past(req_rdy);
	endproperty
	a_ready: assert property (p_ready)                      // R15
		else $error("switched to unready oscillator");
	property p_sxt_en;                                      // R9
		o_sxt_en |-> $past(sxt_en);
	endproperty
	a_sxt_en: assert property (p_sxt_en)                    // R9
		else $error("slow crystal on without enable");
	property p_sleep_fast;                                  // R13
		halted && !sysctl[B_FHID] |=> !o_fast_clk && !o_fxt_en;
	endproperty
	a_sleep_fast: assert property (p_sleep_fast)            // R13
		else $error("fast clock alive in sleep");
	property p_sleep_sub;                                   // R10
		halted && !sysctl[B_FSID] |=> !o_sub_clk && !o_sxt_en;
	endproperty
	a_sleep_sub: assert property (p_sleep_sub)              // R10
		else $error("slow clock alive in sleep");
	property p_stop;                                        // R10
		!sys_run |=> !o_sysclk;
	endproperty
	a_stop: assert property (p_stop)                        // R10
		else $error("system clock runs while stopped");
	property p_fast_one;                                    // R7
		!halted |=> o_fxt_en || o_frc_en;
	endproperty
	a_fast_one: assert property (p_fast_one)                // R7
		else $error("no fast oscillator running");
	property p_pins;                                        // R11
		!o_xt_pins_osc |-> !o_sxt_en;
	endproperty
	a_pins: assert property (p_pins)                        // R11
		else $error("crystal enabled on I/O pins");
	property p_div2;                                        // R12
		sys_run && sys_req && !hold && cur_cks == 3'h1 && fast_rise
			&& !sw |=> ##1 o_sysclk == $past(div_cnt[0]);
	endproperty
	a_div2: assert property (p_div2)                        // R12
		else $error("divide by two output wrong");
endmodule

/* core/oss_pkg.sv */
/*
 Constants for the oscillator source select block: register
 offsets, field positions, reset values, channel indices and
 start-up edge counts. Assumes an 8-bit register port.
*/
package oss_pkg;
	// ==========================================================
	// Register port
	localparam int          ADDR_W   = 3;
	localparam int          DATA_W   = 8;
	localparam logic [2:0]  A_SYSCTL = 3'h0;
	localparam logic [2:0]  A_FRCCTL = 3'h1;
	localparam logic [2:0]  A_FXTCTL = 3'h2;
	localparam logic [2:0]  A_SXTCTL = 3'h3;
	localparam logic [2:0]  A_PINCTL = 3'h4;
	// ==========================================================
	// System clock control fields
	localparam int          B_CKS_HI = 7;
	localparam int          B_CKS_LO = 5;
	localparam int          B_FHS    = 3;
	localparam int          B_FSS    = 2;
	localparam int          B_FHID   = 1;
	localparam int          B_FSID   = 0;
	localparam logic [7:0]  SYSCTL_RST = 8'h00;
	localparam logic [7:0]  SYSCTL_WM  = 8'hef;
	localparam logic [2:0]  CKS_SUB  = 3'h7;
	localparam logic [2:0]  CKS_DIV1 = 3'h0;
	// ==========================================================
	// Oscillator control fields
	localparam int          B_EN     = 0;
	localparam int          B_RDY    = 1;
	localparam int          B_FRQ_LO = 2;
	localparam int          B_FRQ_HI = 3;
	localparam int          B_XTPS   = 0;
	localparam logic [1:0]  FRQ_4M   = 2'h0;
	localparam logic [1:0]  FRQ_8M   = 2'h1;
	localparam logic [1:0]  FRQ_12M  = 2'h2;
	localparam logic [1:0]  FRQ_RST  = FRQ_4M;
	localparam logic        FRC_EN_RST = 1'b1;
	// ==========================================================
	// Oscillator channels and start-up edge counts
	localparam int          N_OSC    = 4;
	localparam int          OSC_FXT  = 0;
	localparam int          OSC_FRC  = 1;
	localparam int          OSC_SXT  = 2;
	localparam int          OSC_SRC  = 3;
	localparam int          START_W  = 11;
	localparam logic [10:0] START_EDGES [N_OSC] =
		'{11'h400, 11'h010, 11'h400, 11'h010};
	localparam int          DIV_W    = 6;
endpackage

/* tb/oscillator_source_select_tb.sv */
/*
 Self-checking bench for the oscillator source select core.
 Assumes the behavioural oscillator model with periods of
 8, 6, 18 and 14 bench cycles.
*/
`timescale 1ns/100ps
module oscillator_source_select_tb;
	import oss_pkg::*;
	// ==========================================================
	// Signals
	logic              i_clk, i_nrst, fxt, frc, sxt, src;
	logic [ADDR_W-1:0] i_addr;
	logic [DATA_W-1:0] i_wdata, o_rdata;
	logic              i_wr, i_rd, i_halt, i_wake, i_wdt_en;
	logic              o_sysclk, o_fast_clk, o_sub_clk, o_slow_internal_rc_clk;
	logic              o_fxt_en, o_frc_en, o_sxt_en, o_src_en;
	logic [1:0]        o_frc_freq;
	logic              o_xt_pins_osc, o_cpu_run, rd_seen;
	logic [3:0]        lvl, prev;
	logic [31:0]       seed;
	logic [15:0]       exp_q [$];
	int                miscompares, checked, per, last, ncyc;
	int                nrise [4];
	oss_core DUT (.i_clk(i_clk), .i_nrst(i_nrst),
		.i_fast_crystal_osc(fxt), .i_fast_internal_rc(frc),
		.i_slow_crystal_osc(sxt), .i_slow_internal_rc(src),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.i_halt(i_halt), .i_wake(i_wake), .i_wdt_en(i_wdt_en),
		.o_rdata(o_rdata), .o_sysclk(o_sysclk), .o_fast_clk(o_fast_clk),
		.o_sub_clk(o_sub_clk), .o_slow_internal_rc_clk(o_slow_internal_rc_clk),
		.o_fxt_en(o_fxt_en), .o_frc_en(o_frc_en), .o_sxt_en(o_sxt_en),
		.o_src_en(o_src_en), .o_frc_freq(o_frc_freq),
		.o_xt_pins_osc(o_xt_pins_osc), .o_cpu_run(o_cpu_run));
	oss_osc_model u_osc (.i_clk(i_clk), .i_fxt_en(o_fxt_en),
		.i_frc_en(o_frc_en), .i_sxt_en(o_sxt_en), .i_src_en(o_src_en),
		.o_fxt(fxt), .o_frc(frc), .o_sxt(sxt), .o_src(src));
	// ==========================================================
	// Clock, hang limit and helpers
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	// Whole run is about 40k cycles; twice that means a hang
	initial begin
		repeat (80000) @(posedge i_clk);
		miscompares++;
		stop_test();
	end
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction
	task check(input string nm, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task stop_test();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Read data stands only in the cycle after the strobe
	always @(posedge i_clk) begin
		if (rd_seen)
			check("o_rdata", exp_q.pop_front(), 16'(o_rdata));
		rd_seen = i_rd;
	end
	// Clock outputs settle mid-cycle; count rises, time o_sysclk
	always @(negedge i_clk) begin
		lvl = {o_slow_internal_rc_clk, o_sub_clk, o_fast_clk, o_sysclk};
		for (int k = 0; k < 4; k++)
			if (lvl[k] && !prev[k])
				nrise[k]++;
		if (lvl[0] && !prev[0]) begin
			per = ncyc - last;
			last = ncyc;
		end
		prev = lvl;
		ncyc++;
	end
	// ==========================================================
	// Bus and measurement tasks
	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
		repeat (3) @(posedge i_clk);
	endtask
	task rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		exp_q.push_back(16'(e));
		@(posedge i_clk);
		i_rd <= 1'b0;
	endtask
	// Third rise from now: skips the changeover pulse
	task measure(input int e);
		int n0;
		n0 = nrise[0];
		for (int t = 0; t < 4000 && nrise[0] < n0 + 3; t++)
			@(posedge i_clk);
		check("sysclk period", 16'(e), 16'(per));
	endtask
	task halt_chk(input logic w, input logic [7:0] sc, input logic [3:0] r);
		int n [4];
		i_wdt_en <= w;
		wr(A_SYSCTL, sc);
		i_halt <= 1'b1;
		@(posedge i_clk);
		i_halt <= 1'b0;
		repeat (20) @(posedge i_clk);
		check("o_cpu_run", 16'h0, 16'(o_cpu_run));
		n = nrise;
		repeat (200) @(posedge i_clk);
		for (int k = 0; k < 4; k++)
			check("clock runs", 16'(r[k]), 16'(nrise[k] != n[k]));
		i_wake <= 1'b1;
		@(posedge i_clk);
		i_wake <= 1'b0;
		repeat (5) @(posedge i_clk);
		check("o_cpu_run", 16'h1, 16'(o_cpu_run));
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		{i_nrst, i_wr, i_rd, i_halt, i_wake, i_addr, i_wdata} = '0;
		{miscompares, checked, per, last, ncyc, rd_seen} = '0;
		prev = '0;
		nrise = '{default: 0};
		i_wdt_en = 1'b1;
		seed = 32'he0cb4d32;
		repeat (12) @(posedge i_clk);
		i_nrst <= 1'b1;
		repeat (3) @(posedge i_clk);
		check("o_frc_en", 16'h1, 16'(o_frc_en));
		check("o_src_en", 16'h1, 16'(o_src_en));
		check("o_sxt_en", 16'h0, 16'(o_sxt_en));
		check("o_xt_pins_osc", 16'h0, 16'(o_xt_pins_osc));
		check("o_frc_freq", 16'(FRQ_RST), 16'(o_frc_freq));
		rd(A_SYSCTL, SYSCTL_RST);
		repeat (200) @(posedge i_clk);
		rd(A_FRCCTL, 8'h03);
		for (int f = 0; f < 3; f++) begin
			wr(A_FRCCTL, {4'h0, 2'(f), 2'b01});
			check("o_frc_freq", 16'(f), 16'(o_frc_freq));
		end
		wr(A_FRCCTL, 8'h01);
		repeat (200) @(posedge i_clk);
		// Unmapped places ignore writes and read 0
		for (int i = 0; i < 3; i++) begin
			seed = xs(seed);
			wr(3'h5 + 3'(seed[1:0] % 3), seed[15:8]);
			rd(3'h5 + 3'(seed[1:0] % 3), 8'h00);
		end
		for (int c = 0; c < 8; c++) begin
			wr(A_SYSCTL, {3'(c), 5'h00});
			measure(c == 7 ? 14 : 6 << c);
		end
		for (int i = 0; i < 3; i++) begin
			seed = xs(seed);
			wr(A_SYSCTL, {seed[2:0], 5'h00});
			measure(seed[2:0] == 3'h7 ? 14 : 6 << seed[2:0]);
		end
		wr(A_PINCTL, 8'h01);
		check("o_xt_pins_osc", 16'h1, 16'(o_xt_pins_osc));
		wr(A_PINCTL, 8'h00);
		check("o_xt_pins_osc", 16'h0, 16'(o_xt_pins_osc));
		wr(A_SXTCTL, 8'h01);
		check("o_sxt_en", 16'h1, 16'(o_sxt_en));
		check("o_xt_pins_osc", 16'h1, 16'(o_xt_pins_osc));
		rd(A_SXTCTL, 8'h01);
		repeat (20000) @(posedge i_clk);
		rd(A_SXTCTL, 8'h03);
		wr(A_SYSCTL, 8'he4);
		measure(18);
		wr(A_SYSCTL, 8'h1c);
		rd(A_SYSCTL, 8'h0c);
		check("o_fxt_en", 16'h1, 16'(o_fxt_en));
		measure(18);
		repeat (9000) @(posedge i_clk);
		measure(8);
		halt_chk(1'b1, 8'h0c, 4'b1000);
		halt_chk(1'b1, 8'h0d, 4'b1100);
		halt_chk(1'b1, 8'h0f, 4'b1111);
		halt_chk(1'b1, 8'h0e, 4'b1011);
		halt_chk(1'b0, 8'h0c, 4'b0000);
		stop_test();
	end
endmodule

/* tb/oss_osc_model.sv */
/*
 Behavioural oscillator cells for the source select core: four
 square waves stepped from the falling edge of the bench clock so
 that divider periods come out exact.
 Assumes the core's run enables gate each cell.
*/
`timescale 1ns/100ps
module oss_osc_model #(
	parameter int HALF_FXT = 4,
	parameter int HALF_FRC = 3,
	parameter int HALF_SXT = 9,
	parameter int HALF_SRC = 7
) (
	input  wire logic i_clk,
	input  wire logic i_fxt_en,
	input  wire logic i_frc_en,
	input  wire logic i_sxt_en,
	input  wire logic i_src_en,
	output logic      o_fxt,
	output logic      o_frc,
	output logic      o_sxt,
	output logic      o_src
);
	// ==========================================================
	// Cells
	localparam int HALF [4] = '{HALF_FXT, HALF_FRC, HALF_SXT, HALF_SRC};
	logic [3:0] en;
	logic [3:0] lvl = 4'h0;
	int         cnt [4] = '{default: 0};
	assign en = {i_src_en, i_sxt_en, i_frc_en, i_fxt_en};
	// Stopped cell sits low, so no edge leaks out before enable
	always @(negedge i_clk) begin
		for (int k = 0; k < 4; k++) begin
			if (!en[k]) begin
				lvl[k] <= 1'b0;
				cnt[k] <= 0;
			end else if (cnt[k] == HALF[k] - 1) begin
				lvl[k] <= ~lvl[k];
				cnt[k] <= 0;
			end else begin
				cnt[k] <= cnt[k] + 1;
			end
		end
	end
	// Cell outputs
	assign o_fxt = lvl[0];
	assign o_frc = lvl[1];
	assign o_sxt = lvl[2];
	assign o_src = lvl[3];
endmodule
